// ===== rtl/fmwpc_pkg.sv
// Package for the frame memory window pointer control block.
// Assumes a single 25 MHz APB clock; port clocks arrive as plain pins.
`default_nettype none
package fmwpc_pkg;
   // APB byte offsets
   localparam logic [7:0] FMWPC_CTRL_OFS = 8'h00;
   localparam logic [7:0] FMWPC_RJMP_OFS = 8'h04;
   localparam logic [7:0] FMWPC_WJMP_OFS = 8'h08;
   localparam logic [7:0] FMWPC_RWIN_OFS = 8'h0c;
   localparam logic [7:0] FMWPC_WWIN_OFS = 8'h10;
   localparam logic [7:0] FMWPC_RPTR_OFS = 8'h14;
   localparam logic [7:0] FMWPC_WPTR_OFS = 8'h18;
   localparam logic [7:0] FMWPC_STAT_OFS = 8'h1c;
   // Field positions
   localparam int FMWPC_LINE_POS = 16;
   localparam int FMWPC_HGT_POS = 16;
   localparam int FMWPC_WIN_POS = 2;
   // Reset values of the size registers
   localparam logic [10:0] FMWPC_WID_RST = 11'h040;
   localparam logic [8:0] FMWPC_HGT_RST = 9'h001;
   // Geometry of the two 2-D addressing modes
   localparam logic [10:0] FMWPC_LLEN_M1 = 11'h400;
   localparam logic [10:0] FMWPC_LLEN_M2 = 11'h480;
   localparam logic [8:0] FMWPC_LMAX_M1 = 9'h144;
   localparam logic [8:0] FMWPC_LMAX_M2 = 9'h120;
   localparam logic [10:0] FMWPC_MIN_WID = 11'h040;
   localparam logic [8:0] FMWPC_MIN_HGT = 9'h001;
   localparam int FMWPC_BLK_SHIFT = 5;
   // Reset spacing in port-clock cycles, and words at risk
   localparam logic [7:0] FMWPC_RD_GAP = 8'h40;
   localparam logic [7:0] FMWPC_WR_GAP = 8'ha0;
   localparam logic [5:0] FMWPC_SUS_WORDS = 6'h20;
   // Pointer in 2-D form
   typedef struct packed {
      logic [8:0] line;
      logic [10:0] dot;
   } fmwpc_ptr_type;
   // Synchronised pin group of one port, all active low but clk
   typedef struct packed {
      logic clk;
      logic gate_n;
      logic rst_n;
      logic aset_n;
      logic lrst_n;
      logic wnd_n;
      logic clr_n;
   } fmwpc_pins_type;
   localparam fmwpc_pins_type FMWPC_PINS_IDLE = 7'h3f;
   // Port commands, one-hot
   typedef enum logic [9:0] {
      FMWPC_NONE = 10'h001,
      FMWPC_STEP = 10'h002,
      FMWPC_LINC = 10'h004,
      FMWPC_LHLD = 10'h008,
      FMWPC_ASET = 10'h010,
      FMWPC_RST = 10'h020,
      FMWPC_WRST = 10'h040,
      FMWPC_JMP = 10'h080,
      FMWPC_WJMP = 10'h100,
      FMWPC_CLR = 10'h200
   } fmwpc_cmd_type;
   // State of one port's pointer machine
   typedef struct packed {
      fmwpc_ptr_type ptr;
      fmwpc_ptr_type org;
      fmwpc_ptr_type jmp;
      logic win;
      fmwpc_cmd_type pend;
      logic pend_v;
      logic [7:0] gap;
      logic [5:0] sus;
      logic flag;
   } fmwpc_side_type;
endpackage
`default_nettype wire

// ===== rtl/fmwpc_top.sv
// Read and write address pointer control of a two-port frame memory.
// Assumes port pins come from outside pclk's domain; APB is on pclk.
//
// Added by the designer: register access over APB and the address map.
`default_nettype none
module fmwpc_top
   import fmwpc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic read_port_clock,
   input wire logic read_clock_gate_n,
   input wire logic read_pointer_reset_n,
   input wire logic read_addr_set_n,
   input wire logic read_line_reset_n,
   input wire logic read_window_select_n,
   input wire logic read_clear_n,
   input wire logic write_port_clock,
   input wire logic write_clock_gate_n,
   input wire logic write_pointer_reset_n,
   input wire logic write_addr_set_n,
   input wire logic write_line_reset_n,
   input wire logic write_window_select_n,
   input wire logic write_clear_n,
   output fmwpc_ptr_type read_addr,
   output fmwpc_ptr_type write_addr,
   output logic read_block_suspect,
   output logic write_block_suspect
);
   // Turn pin levels at a port-clock rise into a command
   function automatic fmwpc_cmd_type fmwpc_decode(input fmwpc_pins_type p);
      fmwpc_cmd_type c;
      c = FMWPC_NONE;
      if (!p.clr_n) begin
         c = FMWPC_CLR;
      end else if (p.rst_n && p.aset_n && p.lrst_n) begin
         c = FMWPC_STEP;
      end else if (p.aset_n && !p.lrst_n) begin
         c = p.rst_n ? FMWPC_LINC : FMWPC_LHLD;
      end else if (p.rst_n && !p.aset_n && p.lrst_n) begin
         c = FMWPC_ASET;
      end else if (!p.rst_n && p.aset_n && p.lrst_n) begin
         c = p.wnd_n ? FMWPC_RST : FMWPC_WRST;
      end else if (!p.rst_n && !p.aset_n && p.lrst_n) begin
         c = p.wnd_n ? FMWPC_JMP : FMWPC_WJMP;
      end
      return c;
   endfunction

   // Reset-type commands are the ones that are queued; they and FMWPC_ASET are spaced
   function automatic logic fmwpc_is_rst(input fmwpc_cmd_type c);
      return (c == FMWPC_RST) || (c == FMWPC_WRST) || (c == FMWPC_JMP) ||
         (c == FMWPC_WJMP) || (c == FMWPC_LINC) || (c == FMWPC_LHLD) ||
         (c == FMWPC_CLR);
   endfunction

   // Apply one command to a port's pointer state
   function automatic fmwpc_side_type fmwpc_exec(
      input fmwpc_side_type s,
      input fmwpc_cmd_type c,
      input logic [10:0] wid,
      input logic [8:0] hgt,
      input logic [10:0] llen,
      input logic [8:0] lmax
   );
      fmwpc_side_type n;
      logic [11:0] rsum;
      logic [9:0] bsum;
      logic [10:0] left;
      logic [10:0] right;
      logic [8:0] top;
      logic [8:0] bot;
      n = s;
      rsum = {1'b0, s.org.dot} + {1'b0, wid} - 12'h001;
      bsum = {1'b0, s.org.line} + {1'b0, hgt} - 10'h001;
      left = s.win ? s.org.dot : 11'h000;
      top = s.win ? s.org.line : 9'h000;
      right = llen - 11'h001;
      bot = lmax - 9'h001;
      if (s.win && rsum < {1'b0, right}) begin
         right = rsum[10:0];
      end
      if (s.win && bsum < {1'b0, bot}) begin
         bot = bsum[8:0];
      end
      case (c)
         FMWPC_STEP: begin
            // Internal address step, halting at line or window end
            if (s.ptr.dot < right) begin
               n.ptr.dot = s.ptr.dot + 11'h001;
            end
            if (s.sus != 6'h00) begin
               n.sus = s.sus - 6'h01;
            end
         end
         FMWPC_LINC: begin
            n.ptr.dot = left;
            n.ptr.line = (s.ptr.line >= bot) ? top : s.ptr.line + 9'h001;
         end
         FMWPC_LHLD: begin
            n.ptr.dot = left;
         end
         FMWPC_RST: begin
            n.ptr = '0;
            n.win = 1'b0;
         end
         FMWPC_WRST: begin
            n.ptr = s.win ? s.org : '0;
         end
         FMWPC_JMP: begin
            n.ptr = s.jmp;
            n.win = 1'b0;
         end
         FMWPC_WJMP: begin
            n.ptr = s.jmp;
            n.org = s.jmp;
            n.win = 1'b1;
         end
         FMWPC_CLR: begin
            n.ptr = '0;
            n.org = '0;
            n.win = 1'b0;
         end
         default: begin
            n = s;
         end
      endcase
      return n;
   endfunction

   // Clamp a requested width to 64 dots .. line length
   function automatic logic [10:0] fmwpc_wid(input logic [10:0] w, input logic [10:0] l);
      logic [10:0] r;
      r = (w < FMWPC_MIN_WID) ? FMWPC_MIN_WID : w;
      return (r > l) ? l : r;
   endfunction

   // Clamp a requested height to 1 .. maximum lines
   function automatic logic [8:0] fmwpc_hgt(input logic [8:0] h, input logic [8:0] m);
      logic [8:0] r;
      r = (h < FMWPC_MIN_HGT) ? FMWPC_MIN_HGT : h;
      return (r > m) ? m : r;
   endfunction

   // Software registers
   logic mode_r; // Low: 1024 x 324, high: 1152 x 288
   fmwpc_ptr_type jreq_r [2]; // Staged jump targets, read then write
   logic [10:0] wid_r [2]; // Window widths
   logic [8:0] hgt_r [2]; // Window heights
   fmwpc_pins_type meta_r [2]; // First synchroniser stage
   fmwpc_pins_type pin_r [2]; // Second synchroniser stage
   logic clk_d_r [2]; // Previous port clock level
   fmwpc_side_type side_r [2]; // Pointer machines
   fmwpc_side_type side_nxt [2];
   logic [31:0] prdata_nxt; // Read data for the coming access phase

   // Bus decode
   wire wr_en = psel && penable && pwrite;
   wire rd_hit_ctrl = (paddr == FMWPC_CTRL_OFS);
   wire [10:0] llen = mode_r ? FMWPC_LLEN_M2 : FMWPC_LLEN_M1;
   wire [8:0] lmax = mode_r ? FMWPC_LMAX_M2 : FMWPC_LMAX_M1;
   wire [1:0] flag_clr = (wr_en && paddr == FMWPC_STAT_OFS) ? pwdata[1:0] : 2'b00;
   wire mapped = (paddr[1:0] == 2'b00) && (paddr <= FMWPC_STAT_OFS);
   fmwpc_pins_type pins_in [2];
   assign pins_in[0] = {read_port_clock, read_clock_gate_n, read_pointer_reset_n,
      read_addr_set_n, read_line_reset_n, read_window_select_n, read_clear_n};
   assign pins_in[1] = {write_port_clock, write_clock_gate_n, write_pointer_reset_n,
      write_addr_set_n, write_line_reset_n, write_window_select_n, write_clear_n};
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Two-stage synchronisers and clock-level history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 2; i++) begin
            meta_r[i] <= FMWPC_PINS_IDLE;
            pin_r[i] <= FMWPC_PINS_IDLE;
            clk_d_r[i] <= 1'b0;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            meta_r[i] <= pins_in[i];
            pin_r[i] <= meta_r[i];
            clk_d_r[i] <= pin_r[i].clk;
         end
      end
   end

   // Per-port next state; each port uses its own registers plus the shared mode_r
   always_comb begin
      fmwpc_cmd_type cmd;
      logic [7:0] lim;
      logic rise;
      cmd = FMWPC_NONE;
      lim = FMWPC_RD_GAP;
      rise = 1'b0;
      for (int i = 0; i < 2; i++) begin
         side_nxt[i] = side_r[i];
         // Software clear first, so a set in the same cycle wins
         if (flag_clr[i]) begin
            side_nxt[i].flag = 1'b0;
         end
         cmd = fmwpc_decode(pin_r[i]);
         lim = (i == 0) ? FMWPC_RD_GAP : FMWPC_WR_GAP;
         rise = pin_r[i].clk && !clk_d_r[i];
         // Every port edge counts toward spacing, gated off or not
         if (rise && side_r[i].gap != 8'hff) begin
            side_nxt[i].gap = side_r[i].gap + 8'h01;
         end
         if (rise && pin_r[i].gate_n) begin
            // Gate off: hold the first reset-type command only
            if (fmwpc_is_rst(cmd) && !side_r[i].pend_v) begin
               side_nxt[i].pend = cmd;
               side_nxt[i].pend_v = 1'b1;
            end
         end else if (rise) begin
            // Gate on: a held command runs at this first edge
            if (side_r[i].pend_v) begin
               cmd = side_r[i].pend;
               side_nxt[i].pend_v = 1'b0;
               side_nxt[i].pend = FMWPC_NONE;
            end
            if (cmd == FMWPC_ASET) begin
               side_nxt[i].jmp = jreq_r[i];
            end
            side_nxt[i] = fmwpc_exec(side_nxt[i], cmd,
               fmwpc_wid(wid_r[i], llen), fmwpc_hgt(hgt_r[i], lmax), llen, lmax);
            // Spacing watch: pointers still move, only data is flagged
            if (fmwpc_is_rst(cmd) || cmd == FMWPC_ASET) begin
               side_nxt[i].gap = 8'h00;
               if (side_r[i].gap < lim) begin
                  side_nxt[i].sus = FMWPC_SUS_WORDS;
                  side_nxt[i].flag = 1'b1;
               end
            end
         end
      end
   end

   // Pointer machine state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 2; i++) begin
            side_r[i] <= '{ptr: '0, org: '0, jmp: '0, win: 1'b0, pend: FMWPC_NONE,
               pend_v: 1'b0, gap: 8'hff, sus: 6'h00, flag: 1'b0};
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            side_r[i] <= side_nxt[i];
         end
      end
   end

   // Register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= 1'b0;
         for (int i = 0; i < 2; i++) begin
            jreq_r[i] <= '0;
            wid_r[i] <= FMWPC_WID_RST;
            hgt_r[i] <= FMWPC_HGT_RST;
         end
      end else if (wr_en) begin
         if (rd_hit_ctrl) begin
            mode_r <= pwdata[0];
         end else if (paddr == FMWPC_RJMP_OFS || paddr == FMWPC_WJMP_OFS) begin
            // Jump target in 32-dot blocks; zero is the caller's concern
            jreq_r[paddr == FMWPC_WJMP_OFS] <= {pwdata[FMWPC_LINE_POS +: 9],
               pwdata[5:0], 5'h00};
         end else if (paddr == FMWPC_RWIN_OFS || paddr == FMWPC_WWIN_OFS) begin
            wid_r[paddr == FMWPC_WWIN_OFS] <= pwdata[10:0];
            hgt_r[paddr == FMWPC_WWIN_OFS] <= pwdata[FMWPC_HGT_POS +: 9];
         end
      end
   end

   // Read data mux; window sizes read back as the clamped values in use
   always_comb begin
      prdata_nxt = 32'h0000_0000;
      if (rd_hit_ctrl) begin
         prdata_nxt[0] = mode_r;
      end else if (paddr == FMWPC_RJMP_OFS || paddr == FMWPC_WJMP_OFS) begin
         prdata_nxt[FMWPC_LINE_POS +: 9] = jreq_r[paddr == FMWPC_WJMP_OFS].line;
         prdata_nxt[5:0] = jreq_r[paddr == FMWPC_WJMP_OFS].dot[10:FMWPC_BLK_SHIFT];
      end else if (paddr == FMWPC_RWIN_OFS || paddr == FMWPC_WWIN_OFS) begin
         prdata_nxt[10:0] = fmwpc_wid(wid_r[paddr == FMWPC_WWIN_OFS], llen);
         prdata_nxt[FMWPC_HGT_POS +: 9] = fmwpc_hgt(hgt_r[paddr == FMWPC_WWIN_OFS], lmax);
      end else if (paddr == FMWPC_RPTR_OFS || paddr == FMWPC_WPTR_OFS) begin
         prdata_nxt[10:0] = side_r[paddr == FMWPC_WPTR_OFS].ptr.dot;
         prdata_nxt[FMWPC_LINE_POS +: 9] = side_r[paddr == FMWPC_WPTR_OFS].ptr.line;
      end else if (paddr == FMWPC_STAT_OFS) begin
         prdata_nxt[1:0] = {side_r[1].flag, side_r[0].flag};
         prdata_nxt[FMWPC_WIN_POS +: 2] = {side_r[1].win, side_r[0].win};
      end
   end

   // Read data taken in the setup phase, held through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= prdata_nxt;
      end
   end

   // Outputs straight from state flops
   assign read_addr = side_r[0].ptr;
   assign write_addr = side_r[1].ptr;
   assign read_block_suspect = (side_r[0].sus != 6'h00);
   assign write_block_suspect = (side_r[1].sus != 6'h00);
endmodule
`default_nettype wire

// ===== verification/fmwpc_sva.sv
// Checker on the ports of the pointer control block.
// Assumes port pins change on pclk edges and settle before sampling.
`default_nettype none
module fmwpc_sva
   import fmwpc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic read_port_clock,
   input wire logic write_port_clock,
   input wire fmwpc_ptr_type read_addr,
   input wire fmwpc_ptr_type write_addr,
   input wire logic read_block_suspect,
   input wire logic write_block_suspect
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [6:0] rq_r; // Read port clock history
   logic [6:0] wq_r; // Write port clock history
   wire rd_rise = |(rq_r[5:1] & ~rq_r[6:2]); // Read rise a few cycles back
   wire wr_rise = |(wq_r[5:1] & ~wq_r[6:2]); // Write rise a few cycles back
   // Shift in port clock levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rq_r <= '0;
         wq_r <= '0;
      end else begin
         rq_r <= {rq_r[5:0], read_port_clock};
         wq_r <= {wq_r[5:0], write_port_clock};
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_apb_ready: assert property (psel && penable |-> pready)
      else $error("pready low in access");
   a_map_ok: assert property (psel && penable && paddr <= 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("error on mapped offset");
   a_unmap_err: assert property (psel && penable && paddr > 8'h1c |-> pslverr && prdata == 32'h0)
      else $error("unmapped offset not refused");
   a_rd_move: assert property (!$stable(read_addr) |-> rd_rise)
      else $error("read pointer moved without port edge");
   a_wr_move: assert property (!$stable(write_addr) |-> wr_rise)
      else $error("write pointer moved without port edge");
   a_rd_suspect: assert property ($rose(read_block_suspect) |-> rd_rise)
      else $error("read suspect without port edge");
   a_wr_suspect: assert property ($rose(write_block_suspect) |-> wr_rise)
      else $error("write suspect without port edge");
   a_ptr_range: assert property (read_addr.dot < FMWPC_LLEN_M2 &&
      write_addr.dot < FMWPC_LLEN_M2)
      else $error("pointer past line end");
endmodule
bind fmwpc_top fmwpc_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .read_port_clock(read_port_clock), .write_port_clock(write_port_clock),
   .read_addr(read_addr), .write_addr(write_addr),
   .read_block_suspect(read_block_suspect), .write_block_suspect(write_block_suspect));
`default_nettype wire

// ===== verification/fmwpc_port_model.sv
// Controller model that drives the pin group of one port.
// Assumes pclk at 25 MHz; the port clock is 8 pclk a period.
`default_nettype none
module fmwpc_port_model
   import fmwpc_pkg::*;
(
   input wire logic pclk,
   output var fmwpc_pins_type pins
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle pins, clock still, until a frame starts
   initial begin
      pins <= FMWPC_PINS_IDLE;
   end
   // Send n port clocks with pins p, then pad idle clocks with gate high
   task automatic send(input fmwpc_pins_type p, input int n, input int pad);
      for (int i = 0; i < n + pad; i++) begin
         @(posedge pclk);
         pins <= (i < n) ? p : FMWPC_PINS_IDLE; // Spacing between resets
         repeat (4) @(posedge pclk);
         pins.clk <= 1'b1;
         repeat (3) @(posedge pclk);
      end
      @(posedge pclk);
      pins <= FMWPC_PINS_IDLE;
      repeat (3) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// ===== verification/fmwpc_tb.sv
// Bench for the pointer block: APB master, two port models, checks.
// Assumes the checker is bound from its own file.
`default_nettype none
module fmwpc_tb
   import fmwpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   fmwpc_pins_type rp; // Read pin group
   fmwpc_pins_type wp; // Write pin group
   fmwpc_ptr_type ra;
   fmwpc_ptr_type wa;
   logic rs;
   logic ws;
   logic [31:0] rd; // Last read data
   logic er; // Last error flag
   int err_total = 0;
   int check_count = 0;
   logic [31:0] cw [3] = '{32'h0000000a, 32'h01ff07ff, 32'h01ff07ff}; // Window writes
   logic [31:0] cx [3] = '{32'h00010040, 32'h01440400, 32'h01200480}; // Clamped readback
   always #20 pclk = ~pclk;
   fmwpc_port_model i_rp (.pclk(pclk), .pins(rp));
   fmwpc_port_model i_wp (.pclk(pclk), .pins(wp));
   fmwpc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .read_port_clock(rp.clk), .read_clock_gate_n(rp.gate_n),
      .read_pointer_reset_n(rp.rst_n), .read_addr_set_n(rp.aset_n),
      .read_line_reset_n(rp.lrst_n), .read_window_select_n(rp.wnd_n), .read_clear_n(rp.clr_n),
      .write_port_clock(wp.clk), .write_clock_gate_n(wp.gate_n),
      .write_pointer_reset_n(wp.rst_n), .write_addr_set_n(wp.aset_n),
      .write_line_reset_n(wp.lrst_n), .write_window_select_n(wp.wnd_n),
      .write_clear_n(wp.clr_n), .read_addr(ra), .write_addr(wa),
      .read_block_suspect(rs), .write_block_suspect(ws));
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // Compare a pointer against line and dot
   task automatic ckp(input string nm, input fmwpc_ptr_type p, input int l, input int d);
      chk(nm, {12'h0, 9'(l), 11'(d)}, {12'h0, p});
   endtask
   // One APB transfer; data and error taken at the ready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic end_of_test;
      $display("Checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      repeat (40000) @(posedge pclk);
      err_total++;
      end_of_test();
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      ckp("read_addr", ra, 0, 0);
      apb(1'b0, FMWPC_RWIN_OFS, 32'h0);
      chk("read window", 32'h00010040, rd);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, er});
      i_rp.send(7'h1f, 3, 0);
      ckp("read_addr", ra, 0, 3);
      i_rp.send(7'h2f, 1, 1);
      i_rp.send(7'h3b, 1, 1);
      i_rp.send(7'h1f, 1, 64);
      ckp("read_addr", ra, 0, 0);
      apb(1'b1, FMWPC_RJMP_OFS, 32'h00030002);
      apb(1'b1, FMWPC_RWIN_OFS, 32'h00020040);
      i_rp.send(7'h17, 1, 64);
      i_rp.send(7'h05, 1, 64);
      ckp("read_addr", ra, 3, 64);
      i_rp.send(7'h1f, 70, 0);
      ckp("read_addr", ra, 3, 127);
      i_rp.send(7'h1b, 1, 64);
      ckp("read_addr", ra, 4, 64);
      i_rp.send(7'h1f, 1, 0);
      i_rp.send(7'h09, 1, 64); // Line hold in window
      ckp("read_addr", ra, 4, 64);
      i_rp.send(7'h1f, 1, 0);
      i_rp.send(7'h0d, 1, 64);
      ckp("read_addr", ra, 3, 64);
      apb(1'b0, FMWPC_RPTR_OFS, 32'h0);
      chk("read pointer reg", 32'h00030040, rd);
      apb(1'b0, FMWPC_STAT_OFS, 32'h0);
      chk("window status", 32'h00000004, rd);
      i_rp.send(7'h1e, 1, 64);
      i_rp.send(7'h1f, 1, 0);
      ckp("read_addr", ra, 0, 1);
      i_rp.send(7'h0f, 1, 2);
      i_rp.send(7'h0f, 1, 64);
      chk("read suspect", 32'h1, {31'h0, rs});
      ckp("read_addr", ra, 0, 0);
      apb(1'b0, FMWPC_STAT_OFS, 32'h0);
      chk("status read bit", 32'h1, {31'h0, rd[0]});
      i_rp.send(7'h1f, 33, 0);
      ckp("read_addr", ra, 0, 33);
      chk("read suspect", 32'h0, {31'h0, rs});
      apb(1'b1, FMWPC_STAT_OFS, 32'h1);
      apb(1'b0, FMWPC_STAT_OFS, 32'h0);
      chk("status clear", 32'h0, {31'h0, rd[0]});
      i_wp.send(7'h1f, 5, 0);
      ckp("write_addr", wa, 0, 5);
      i_wp.send(7'h3b, 1, 1);
      i_wp.send(7'h2f, 1, 1);
      i_wp.send(7'h1f, 1, 160);
      ckp("write_addr", wa, 1, 0);
      ckp("read_addr", ra, 0, 33);
      apb(1'b1, FMWPC_WJMP_OFS, 32'h00050001);
      i_wp.send(7'h17, 1, 160);
      i_wp.send(7'h07, 1, 160);
      ckp("write_addr", wa, 5, 32);
      i_wp.send(7'h0f, 1, 2);
      i_wp.send(7'h0f, 1, 160);
      chk("write suspect", 32'h1, {31'h0, ws});
      ckp("write_addr", wa, 0, 0);
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, FMWPC_CTRL_OFS, {31'h0, i == 2});
         apb(1'b1, FMWPC_WWIN_OFS, cw[i]);
         apb(1'b0, FMWPC_WWIN_OFS, 32'h0);
         chk("write window", cx[i], rd);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
